// file: rtl/lsd_pkg.sv
// Constants and types of the LCD setup command decoder
package lsd_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_OPERAND    = 8'h00;
  localparam logic [7:0] REG_COMMAND    = 8'h04;
  localparam logic [7:0] REG_CURSOR     = 8'h08;
  localparam logic [7:0] REG_OFFSET     = 8'h0C;
  localparam logic [7:0] REG_ADDR_PTR   = 8'h10;
  localparam logic [7:0] REG_TEXT_HOME  = 8'h14;
  localparam logic [7:0] REG_TEXT_COLS  = 8'h18;
  localparam logic [7:0] REG_GFX_HOME   = 8'h1C;
  localparam logic [7:0] REG_GFX_COLS   = 8'h20;
  localparam logic [7:0] REG_MODE       = 8'h24;
  localparam logic [7:0] REG_STATUS     = 8'h28;

  // Command codes
  localparam logic [7:0] CMD_CURSOR     = 8'h21;
  localparam logic [7:0] CMD_OFFSET     = 8'h22;
  localparam logic [7:0] CMD_ADDR_PTR   = 8'h24;
  localparam logic [7:0] CMD_TEXT_HOME  = 8'h40;
  localparam logic [7:0] CMD_TEXT_AREA  = 8'h41;
  localparam logic [7:0] CMD_GFX_HOME   = 8'h42;
  localparam logic [7:0] CMD_GFX_AREA   = 8'h43;
  localparam logic [3:0] CMD_MODE_TOP   = 4'h8;

  // Field positions and the character-generator ROM limit
  localparam int CURSOR_ROW_POS = 8;
  localparam int MODE_CG_BIT    = 3;
  localparam int CG_CODE_POS    = 3;
  localparam int CG_OFFSET_POS  = 11;
  localparam int STAT_DUAL_BIT  = 8;
  localparam int STAT_BAD_BIT   = 9;
  localparam logic [7:0] CG_ROM_LIMIT = 8'h80;

  // Hardware column counts by select pins {b,a}
  localparam logic [7:0] HW_COLS_LL = 8'h50;
  localparam logic [7:0] HW_COLS_LH = 8'h40;
  localparam logic [7:0] HW_COLS_HL = 8'h28;
  localparam logic [7:0] HW_COLS_HH = 8'h20;

  // Reset values
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    LSD_COMB_OR   = 3'b000,
    LSD_COMB_XOR  = 3'b001,
    LSD_COMB_AND  = 3'b011,
    LSD_COMB_ATTR = 3'b100
  } lsd_combine_t;

endpackage : lsd_pkg

// file: rtl/lsd_addr_gen.sv
// Registered display and character-generator address arithmetic
`timescale 1ns/1ps
module lsd_addr_gen (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Settings
  input  wire logic [15:0]  textHome,
  input  wire logic [7:0]   textStride,
  input  wire logic [15:0]  graphicHome,
  input  wire logic [7:0]   graphicStride,
  input  wire logic [4:0]   offsetBits,
  input  wire logic         externalCg,
  // Request
  input  wire logic         fetchValid,
  input  wire logic [4:0]   fetchRow,
  input  wire logic [6:0]   fetchCol,
  input  wire logic [7:0]   fetchCode,
  input  wire logic [2:0]   fetchDotRow,
  // Answer
  output logic              fetchDone,
  output logic [15:0]       textAddr,
  output logic [15:0]       graphicAddr,
  output logic [15:0]       cgAddr,
  output logic              cgFromRam
);
  import lsd_pkg::*;

  wire logic [12:0] textOff;
  wire logic [12:0] gfxOff;
  wire logic [15:0] textSum;
  wire logic [15:0] gfxSum;
  wire logic [15:0] cgSum;
  wire logic        fromRam;

  assign textOff = 13'(fetchRow) * 13'(textStride);
  assign gfxOff  = 13'(fetchRow) * 13'(graphicStride);
  assign textSum = 16'(textHome + 16'(textOff) + 16'(fetchCol));
  assign gfxSum  = 16'(graphicHome + 16'(gfxOff) + 16'(fetchCol));
  assign cgSum   = {offsetBits, fetchCode, fetchDotRow};
  assign fromRam = externalCg || (fetchCode >= CG_ROM_LIMIT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetchDone   <= 1'b0;
      textAddr    <= RST_ADDR;
      graphicAddr <= RST_ADDR;
      cgAddr      <= RST_ADDR;
      cgFromRam   <= 1'b0;
    end else begin
      fetchDone <= fetchValid;
      if (fetchValid) begin
        textAddr    <= textSum;
        graphicAddr <= gfxSum;
        cgAddr      <= cgSum;
        cgFromRam   <= fromRam;
      end
    end
  end

endmodule : lsd_addr_gen

// file: rtl/lsd_setup_decoder.sv
// Setup command decoder with AHB-Lite register access and address generation
`timescale 1ns/1ps
module lsd_setup_decoder (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Configuration pins
  input  wire logic         columnSelectA,
  input  wire logic         columnSelectB,
  input  wire logic         dualScan,
  // Display fetch request
  input  wire logic         fetchValid,
  input  wire logic [4:0]   fetchRow,
  input  wire logic [6:0]   fetchCol,
  input  wire logic [7:0]   fetchCode,
  input  wire logic [2:0]   fetchDotRow,
  // Display fetch answer
  output logic              fetchDone,
  output logic [15:0]       textAddr,
  output logic [15:0]       graphicAddr,
  output logic [15:0]       cgAddr,
  output logic              cgFromRam,
  // Settings shown to the display path
  output logic [15:0]       addrPointer,
  output logic [6:0]        cursorCol,
  output logic [3:0]        cursorLine,
  output logic              cursorLowerHalf,
  output logic [2:0]        combineMode,
  output logic              externalCg,
  output logic              attributeMode
);
  import lsd_pkg::*;

  // Bus address phase decode
  wire logic        addrPhase;
  wire logic        wrPhase;
  wire logic        rdPhase;
  logic             wrPend_reg;
  logic [7:0]       wrAddr_reg;

  assign addrPhase = hsel && htrans[1] && hready;
  assign wrPhase   = addrPhase && hwrite;
  assign rdPhase   = addrPhase && !hwrite;

  // Data phase write strobes
  wire logic        operandWr;
  wire logic        commandWr;
  wire logic [7:0]  wrByte;

  assign wrByte    = hwdata[7:0];
  assign operandWr = wrPend_reg && (wrAddr_reg == REG_OPERAND);
  assign commandWr = wrPend_reg && (wrAddr_reg == REG_COMMAND);

  // Operand history: only the two latest bytes are kept
  logic [7:0]       opOld_reg;
  logic [7:0]       opNew_reg;

  // Command decode on the written command byte; operand word from the two latest operands
  wire logic        isCursor;
  wire logic        isOffset;
  wire logic        isAddrPtr;
  wire logic        isTextHome;
  wire logic        isTextArea;
  wire logic        isGfxHome;
  wire logic        isGfxArea;
  wire logic        isModeSet;
  wire logic        isKnown;
  wire logic [15:0] opWord;

  assign isCursor   = commandWr && (wrByte == CMD_CURSOR);
  assign isOffset   = commandWr && (wrByte == CMD_OFFSET);
  assign isAddrPtr  = commandWr && (wrByte == CMD_ADDR_PTR);
  assign isTextHome = commandWr && (wrByte == CMD_TEXT_HOME);
  assign isTextArea = commandWr && (wrByte == CMD_TEXT_AREA);
  assign isGfxHome  = commandWr && (wrByte == CMD_GFX_HOME);
  assign isGfxArea  = commandWr && (wrByte == CMD_GFX_AREA);
  assign isModeSet  = commandWr && (wrByte[7:4] == CMD_MODE_TOP);
  assign isKnown    = isCursor || isOffset || isAddrPtr || isTextHome
                   || isTextArea || isGfxHome || isGfxArea || isModeSet;
  assign opWord     = {opNew_reg, opOld_reg};

  // Setting registers
  logic [6:0]       curCol_reg;
  logic [4:0]       curRow_reg;
  logic [4:0]       offset_reg;
  logic [15:0]      adp_reg;
  logic [15:0]      textHome_reg;
  logic [7:0]       textCols_reg;
  logic             textColsSet_reg;
  logic [15:0]      gfxHome_reg;
  logic [7:0]       gfxCols_reg;
  logic             gfxColsSet_reg;
  logic [2:0]       combine_reg;
  logic             extCg_reg;
  logic             badCmd_reg;

  // Hardware column count from select pins
  wire logic [7:0]  hwColumns;
  wire logic [7:0]  textStride;
  wire logic [7:0]  gfxStride;
  wire logic [7:0]  gfxEffStride;
  wire logic        attrNow;

  assign hwColumns  = columnSelectB ? (columnSelectA ? HW_COLS_HH : HW_COLS_HL)
                                    : (columnSelectA ? HW_COLS_LH : HW_COLS_LL);
  assign textStride = textColsSet_reg ? textCols_reg : hwColumns;
  assign gfxStride  = gfxColsSet_reg ? gfxCols_reg : hwColumns;
  assign attrNow    = (combine_reg == LSD_COMB_ATTR);
  // Attributes sit at the same offset in the graphic area as their character
  assign gfxEffStride = attrNow ? textStride : gfxStride;

  // Data phase of a write follows its address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
    end else begin
      wrPend_reg <= wrPhase;
    end
  end

  // Write address held for the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrAddr_reg <= RST_BYTE;
    end else if (wrPhase) begin
      wrAddr_reg <= haddr[7:0];
    end
  end

  // Operand byte shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opOld_reg <= RST_BYTE;
      opNew_reg <= RST_BYTE;
    end else if (operandWr) begin
      opOld_reg <= opNew_reg;
      opNew_reg <= wrByte;
    end
  end

  // Cursor: no other path writes these
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      curCol_reg <= 7'h00;
      curRow_reg <= 5'h00;
    end else if (isCursor) begin
      curCol_reg <= opOld_reg[6:0];
      curRow_reg <= opNew_reg[4:0];
    end
  end

  // Character-generator offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_reg <= 5'h00;
    end else if (isOffset) begin
      offset_reg <= opOld_reg[4:0];
    end
  end

  // Address pointer for host accesses to display memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adp_reg <= RST_ADDR;
    end else if (isAddrPtr) begin
      adp_reg <= opWord;
    end
  end

  // Text home address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      textHome_reg <= RST_ADDR;
    end else if (isTextHome) begin
      textHome_reg <= opWord;
    end
  end

  // Text column count, replacing the pin count once written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      textCols_reg    <= RST_BYTE;
      textColsSet_reg <= 1'b0;
    end else if (isTextArea) begin
      textCols_reg    <= opOld_reg;
      textColsSet_reg <= 1'b1;
    end
  end

  // Graphic home address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gfxHome_reg <= RST_ADDR;
    end else if (isGfxHome) begin
      gfxHome_reg <= opWord;
    end
  end

  // Graphic column count, replacing the pin count once written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gfxCols_reg    <= RST_BYTE;
      gfxColsSet_reg <= 1'b0;
    end else if (isGfxArea) begin
      gfxCols_reg    <= opOld_reg;
      gfxColsSet_reg <= 1'b1;
    end
  end

  // Mode set holds until the next mode-set command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      combine_reg <= LSD_COMB_OR;
      extCg_reg   <= 1'b0;
    end else if (isModeSet) begin
      combine_reg <= wrByte[2:0];
      extCg_reg   <= wrByte[MODE_CG_BIT];
    end
  end

  // Unknown command flag, cleared by the next known command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      badCmd_reg <= 1'b0;
    end else if (commandWr) begin
      badCmd_reg <= !isKnown;
    end
  end

  // Pointer and cursor toward the display path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrPointer     <= RST_ADDR;
      cursorCol       <= 7'h00;
      cursorLine      <= 4'h0;
      cursorLowerHalf <= 1'b0;
    end else begin
      addrPointer     <= adp_reg;
      cursorCol       <= curCol_reg;
      cursorLine      <= curRow_reg[3:0];
      cursorLowerHalf <= dualScan && curRow_reg[4];
    end
  end

  // Display mode toward the display path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      combineMode     <= LSD_COMB_OR;
      externalCg      <= 1'b0;
      attributeMode   <= 1'b0;
    end else begin
      combineMode     <= combine_reg;
      externalCg      <= extCg_reg;
      attributeMode   <= attrNow;
    end
  end

  // Read words, one per readable register
  wire logic        rdInRange;
  wire logic [7:0]  rdAddr;
  wire logic [31:0] rdCursor;
  wire logic [31:0] rdOffset;
  wire logic [31:0] rdAddrPtr;
  wire logic [31:0] rdTextHome;
  wire logic [31:0] rdTextCols;
  wire logic [31:0] rdGfxHome;
  wire logic [31:0] rdGfxCols;
  wire logic [31:0] rdMode;
  wire logic [31:0] rdStatus;
  wire logic [31:0] rdMux;

  assign rdInRange  = (haddr[31:8] == 24'h00_0000);
  assign rdAddr     = haddr[7:0];
  assign rdCursor   = {19'h0_0000, curRow_reg, 1'b0, curCol_reg};
  assign rdOffset   = {27'h000_0000, offset_reg};
  assign rdAddrPtr  = {16'h0000, adp_reg};
  assign rdTextHome = {16'h0000, textHome_reg};
  assign rdTextCols = {24'h00_0000, textStride};
  assign rdGfxHome  = {16'h0000, gfxHome_reg};
  assign rdGfxCols  = {24'h00_0000, gfxStride};
  assign rdMode     = {28'h000_0000, extCg_reg, combine_reg};
  assign rdStatus   = {22'h00_0000, badCmd_reg, dualScan, hwColumns};
  // Unmapped and out-of-range reads return zero
  assign rdMux = !rdInRange                ? 32'h0000_0000 :
                 (rdAddr == REG_CURSOR)    ? rdCursor      :
                 (rdAddr == REG_OFFSET)    ? rdOffset      :
                 (rdAddr == REG_ADDR_PTR)  ? rdAddrPtr     :
                 (rdAddr == REG_TEXT_HOME) ? rdTextHome    :
                 (rdAddr == REG_TEXT_COLS) ? rdTextCols    :
                 (rdAddr == REG_GFX_HOME)  ? rdGfxHome     :
                 (rdAddr == REG_GFX_COLS)  ? rdGfxCols     :
                 (rdAddr == REG_MODE)      ? rdMode        :
                 (rdAddr == REG_STATUS)    ? rdStatus      :
                                             32'h0000_0000;

  // Zero-wait OKAY slave
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPhase) begin
      hrdata <= rdMux;
    end
  end

  lsd_addr_gen u_addr_gen (
    .clk           (clk),
    .rst           (rst),
    .textHome      (textHome_reg),
    .textStride    (textStride),
    .graphicHome   (gfxHome_reg),
    .graphicStride (gfxEffStride),
    .offsetBits    (offset_reg),
    .externalCg    (extCg_reg),
    .fetchValid    (fetchValid),
    .fetchRow      (fetchRow),
    .fetchCol      (fetchCol),
    .fetchCode     (fetchCode),
    .fetchDotRow   (fetchDotRow),
    .fetchDone     (fetchDone),
    .textAddr      (textAddr),
    .graphicAddr   (graphicAddr),
    .cgAddr        (cgAddr),
    .cgFromRam     (cgFromRam)
  );

endmodule : lsd_setup_decoder

// file: verif/lsd_setup_decoder_properties.sv
// Port checker of the setup command decoder
`timescale 1ns/1ps
module lsd_setup_decoder_checker (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Fetch and settings
  input wire logic        fetchValid,
  input wire logic [7:0]  fetchCode,
  input wire logic [2:0]  fetchDotRow,
  input wire logic        fetchDone,
  input wire logic [15:0] cgAddr,
  input wire logic        cgFromRam,
  input wire logic [6:0]  cursorCol,
  input wire logic [2:0]  combineMode,
  input wire logic        externalCg,
  input wire logic        attributeMode
);
  import lsd_pkg::*;
  logic cmdPhase;
  logic curHit;
  logic modeHit;
  wire  cmdAddr = hsel && htrans[1] && hready && hwrite && (haddr == 32'(REG_COMMAND));
  // Marks the data phase of a command write and what it carried
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmdPhase <= 1'b0;
      curHit   <= 1'b0;
      modeHit  <= 1'b0;
    end else begin
      cmdPhase <= cmdAddr;
      curHit   <= cmdPhase && (hwdata[7:0] == CMD_CURSOR);
      modeHit  <= cmdPhase && (hwdata[7:4] == CMD_MODE_TOP);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_DONE_ONE: assert property (fetchValid |=> fetchDone)
    else $error("fetch not answered next cycle");
  AST_DONE_ONLY: assert property (!fetchValid |=> !fetchDone)
    else $error("fetch done without request");
  AST_CG_LOW: assert property (fetchValid |=> cgAddr[10:0] == {$past(fetchCode), $past(fetchDotRow)})
    else $error("character address low part wrong");
  AST_CG_HIGH: assert property (fetchValid && fetchCode[7] |=> cgFromRam)
    else $error("upper codes not from ram");
  AST_CG_ROM: assert property (fetchValid && !fetchCode[7] && !externalCg ##1 !externalCg |-> !cgFromRam)
    else $error("lower codes not from rom");
  AST_CG_EXT: assert property (fetchValid && externalCg ##1 externalCg |-> cgFromRam)
    else $error("external mode not from ram");
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_CURSOR_ONLY: assert property ($changed(cursorCol) && !$past(rst) |-> $past(curHit))
    else $error("cursor moved without cursor command");
  AST_MODE_HOLD: assert property ($changed(combineMode) && !$past(rst) |-> $past(modeHit))
    else $error("combine mode changed without mode set");
  AST_ATTR: assert property (attributeMode == (combineMode == LSD_COMB_ATTR))
    else $error("attribute flag disagrees with combine mode");
  cover property (fetchValid && fetchCode[7]);
  cover property ($changed(cursorCol));
  cover property (attributeMode && externalCg);
endmodule : lsd_setup_decoder_checker

bind lsd_setup_decoder lsd_setup_decoder_checker i_chk (.clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .fetchValid, .fetchCode, .fetchDotRow,
  .fetchDone, .cgAddr, .cgFromRam, .cursorCol, .combineMode, .externalCg, .attributeMode);

// file: verif/lsd_host_model.sv
// Host processor model: bus master writing operands and command bytes
`timescale 1ns/1ps
module lsd_host_model (
  // Clock
  input  wire logic        clk,
  // Bus master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Hang flag
  output logic             stuck
);
  import lsd_pkg::*;
  initial begin
    {hsel, htrans, hwrite, stuck} = '0;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!hready && n < 16);
    if (!hready) stuck <= 1'b1;
  endtask : wait_ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~{24'h0, a};
    hwdata <= wr ? d : ~hwdata;
    wait_ready();
    q = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
  // Operands first, readiness check before a command with a clear top bit
  task automatic command(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] code);
    logic [31:0] q;
    xfer(1'b1, REG_OPERAND, {24'h0, d1}, q);
    xfer(1'b1, REG_OPERAND, {24'h0, d2}, q);
    if (!code[7]) xfer(1'b0, REG_STATUS, 32'h0, q);
    xfer(1'b1, REG_COMMAND, {24'h0, code}, q);
  endtask : command
endmodule : lsd_host_model

// file: verif/test_lcd_setup_command_decoder.sv
// Self-checking bench of the setup command decoder
`timescale 1ns/1ps
module test_lcd_setup_command_decoder;
  import lsd_pkg::*;
  typedef struct { string nm; logic rd; logic [63:0] v; } lsd_note_t;
  logic        clk = 1'b0, rst = 1'b1;
  logic        hsel, hwrite, hreadyout, hresp, stuck, fetchDone, cgFromRam;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, combineMode;
  logic        columnSelectA = 1'b1, columnSelectB = 1'b1, dualScan = 1'b0;
  logic        fetchValid = 1'b0, cursorLowerHalf, externalCg, attributeMode;
  logic [4:0]  fetchRow = 5'h0;
  logic [6:0]  fetchCol = 7'h0, cursorCol;
  logic [7:0]  fetchCode = 8'h0, b0, b1, b2;
  logic [2:0]  fetchDotRow = 3'h0;
  logic [15:0] textAddr, graphicAddr, cgAddr, addrPointer;
  logic [3:0]  cursorLine;
  int          bad_count = 0, cmp_count = 0, cyc = 0;
  lsd_note_t   notes[$], n;
  logic [31:0] lfsr = 32'h4042;
  logic        rdPh = 1'b0, extCg = 1'b0, attrOn = 1'b0;
  logic [15:0] tHome = 16'h0, gHome = 16'h0;
  logic [7:0]  tCols = HW_COLS_HH, gCols = HW_COLS_HH;
  logic [4:0]  offBits = 5'h0;
  logic [7:0]  hwc [4] = '{HW_COLS_LL, HW_COLS_LH, HW_COLS_HL, HW_COLS_HH};
  logic [7:0]  modes [8] = '{8'h80, 8'h81, 8'h83, 8'h84, 8'h88, 8'h89, 8'h8B, 8'h8C};

  always #5 clk = ~clk;

  lsd_setup_decoder i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .columnSelectA, .columnSelectB,
    .dualScan, .fetchValid, .fetchRow, .fetchCol, .fetchCode, .fetchDotRow, .fetchDone,
    .textAddr, .graphicAddr, .cgAddr, .cgFromRam, .addrPointer, .cursorCol, .cursorLine,
    .cursorLowerHalf, .combineMode, .externalCg, .attributeMode);
  lsd_host_model i_host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .stuck);

  function automatic void rnd(output logic [7:0] r);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    r = lfsr[7:0];
  endfunction : rnd
  task automatic compare(input string nm, input logic [63:0] e, input logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : compare
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic expect_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{nm, 1'b1, 64'(e)});
    i_host.xfer(1'b0, a, 32'h0, q);
  endtask : expect_rd
  // One request a cycle; the caller lowers the request when done
  task automatic fetch(input logic [4:0] r, input logic [6:0] c, input logic [7:0] k,
                       input logic [2:0] d);
    logic [7:0] gs;
    gs = attrOn ? tCols : gCols;
    notes.push_back('{"fetch", 1'b0, {tHome + 16'(r) * 16'(tCols) + 16'(c),
      gHome + 16'(r) * 16'(gs) + 16'(c), offBits, k, d, 15'h0, extCg | k[7]}});
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchRow <= r;
    fetchCol <= c;
    fetchCode <= k;
    fetchDotRow <= d;
  endtask : fetch
  task automatic burst(input int cnt);
    logic [7:0] a, b, c;
    repeat (cnt) begin
      rnd(a);
      rnd(b);
      rnd(c);
      fetch(a[4:0], b[6:0], c, a[7:5]);
    end
    @(posedge clk);
    fetchValid <= 1'b0;
  endtask : burst

  // Result watcher: takes the oldest note when a result of the same kind (read or fetch) appears
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000 || stuck) begin
      bad_count++;
      final_report();
    end
    if (rdPh && notes.size() > 0 && notes[0].rd) begin
      n = notes.pop_front();
      compare(n.nm, n.v, 64'(hrdata));
    end
    if (fetchDone) begin
      if (notes.size() > 0 && !notes[0].rd) n = notes.pop_front();
      else n = '{"extra fetch", 1'b0, 64'h0};
      compare(n.nm, n.v, {textAddr, graphicAddr, cgAddr, 15'h0, cgFromRam});
    end
    rdPh <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    expect_rd("cursor reset", REG_CURSOR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {columnSelectB, columnSelectA} <= 2'(i);
      dualScan <= i[0];
      expect_rd("status", REG_STATUS, {23'h0, i[0], hwc[i]});
    end
    expect_rd("unmapped", 8'h30, 32'h0);
    $display("test pins done");
    i_host.command(8'hCF, 8'hFF, CMD_CURSOR);
    expect_rd("cursor", REG_CURSOR, 32'h1F4F);
    compare("cursor dual", 64'({cursorCol, cursorLine, cursorLowerHalf}), 64'h9FF);
    dualScan <= 1'b0;
    repeat (3) @(posedge clk);
    compare("cursor single", 64'({cursorLine, cursorLowerHalf}), 64'h1E);
    $display("test cursor done");
    rnd(b0);
    rnd(b1);
    rnd(b2);
    i_host.xfer(1'b1, REG_OPERAND, {24'h0, b0}, q);
    i_host.command(b1, b2, CMD_ADDR_PTR);
    expect_rd("pointer", REG_ADDR_PTR, {16'h0, b2, b1});
    compare("pointer pins", 64'(addrPointer), 64'({b2, b1}));
    expect_rd("cursor kept", REG_CURSOR, 32'h1F4F);
    i_host.command(b0, 8'h00, CMD_OFFSET);
    offBits = b0[4:0];
    expect_rd("offset", REG_OFFSET, 32'(b0[4:0]));
    i_host.command(8'h00, 8'h00, 8'h30);
    expect_rd("bad command", REG_STATUS, 32'h220);
    $display("test pointer done");
    burst(6);
    i_host.command(b0, 8'hFF, CMD_TEXT_HOME);
    tHome = {8'hFF, b0};
    i_host.command(b1, b2, CMD_GFX_HOME);
    gHome = {b2, b1};
    burst(8);
    i_host.command(8'h14, 8'h00, CMD_TEXT_AREA);
    tCols = 8'h14;
    i_host.command(b2, 8'h00, CMD_GFX_AREA);
    gCols = b2;
    expect_rd("text cols", REG_TEXT_COLS, 32'h14);
    expect_rd("graphic cols", REG_GFX_COLS, 32'(b2));
    burst(8);
    $display("test address done");
    foreach (modes[i]) begin
      i_host.command(8'h00, 8'h00, modes[i]);
      extCg = modes[i][3];
      attrOn = (modes[i][2:0] == 3'b100);
      expect_rd("mode", REG_MODE, 32'(modes[i][3:0]));
      compare("mode pins", 64'({combineMode, externalCg, attributeMode}),
              64'({modes[i][2:0], extCg, attrOn}));
      fetch(5'h1F, 7'h4F, 8'h7F, 3'h7);
      fetch(5'h10, 7'h00, 8'h80, 3'h0);
      burst(2);
    end
    i_host.command(8'h20, 8'h00, CMD_GFX_AREA);
    expect_rd("mode kept", REG_MODE, 32'hC);
    $display("test mode done");
    repeat (4) @(posedge clk);
    compare("bus okay", 64'h1, 64'({hresp, hreadyout}));
    compare("pending notes", 64'h0, 64'(notes.size()));
    final_report();
  end
endmodule : test_lcd_setup_command_decoder
